//--- design/cpp_pkg.sv
package cpp_pkg;

    // Timebase.
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned HZ_PER_MHZ    = 1_000_000;

    // Settling delay after the supply passes the power-on level.
    localparam int unsigned POR_DELAY_MS  = 10;
    localparam int unsigned POR_DELAY_CYC = CLK_HZ / 1000 * POR_DELAY_MS;

    // Blanking time shared by the battery and current guards.
    localparam int unsigned BLANK_US      = 180;
    localparam int unsigned BLANK_CYC     = CLK_HZ / HZ_PER_MHZ * BLANK_US;

    // Longest allowed reaction to an input surge.
    localparam int unsigned OVP_RESP_NS   = 1000;
    localparam int unsigned OVP_RESP_CYC  = CLK_HZ / HZ_PER_MHZ * OVP_RESP_NS / 1000;

    // Soft-start ramp.
    localparam int unsigned SS_STEP_CYC   = 40;
    localparam int unsigned RAMP_W        = 8;
    localparam logic [7:0]  RAMP_FULL     = 8'hFF;

    // Repeated-fault counters.
    localparam int unsigned CNT_W         = 4;
    localparam logic [3:0]  CNT_LAST      = 4'hF;

    // Positions of the synchronised pin inputs.
    localparam int unsigned SYN_N         = 5;
    localparam int unsigned SYN_VIN       = 0;
    localparam int unsigned SYN_SURGE     = 1;
    localparam int unsigned SYN_HOT       = 2;
    localparam int unsigned SYN_COOL      = 3;
    localparam int unsigned SYN_EN_N      = 4;
    localparam logic [4:0]  SYN_RESET     = 5'h10;

    typedef enum logic [2:0] {
        ST_POR    = 3'h0,
        ST_HOLD   = 3'h1,
        ST_SOFT   = 3'h2,
        ST_ON     = 3'h3
    } cpp_state_t;

endpackage : cpp_pkg

//--- design/cpp_qualify.sv
module cpp_qualify #(
    parameter int unsigned BLANK_CYC = cpp_pkg::BLANK_CYC
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Raw comparator flag from outside the clock domain.
    input  wire logic flag_raw,
    // Qualified level and one-cycle event at qualification.
    output logic      qual_r,
    output logic      event_r
);
    localparam int unsigned W = $clog2(BLANK_CYC + 1);

    logic         s1_r;
    logic         s2_r;
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         qual_nxt;
    logic         event_nxt;

    // The flag must stay high for the full blanking time before it counts.
    always_comb begin
        cnt_nxt   = cnt_r;
        qual_nxt  = qual_r;
        event_nxt = 1'b0;
        if (!s2_r) begin
            cnt_nxt  = '0;
            qual_nxt = 1'b0;
        end else if (cnt_r == W'(BLANK_CYC - 1)) begin
            qual_nxt  = 1'b1;
            event_nxt = !qual_r;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            cnt_r   <= '0;
            qual_r  <= 1'b0;
            event_r <= 1'b0;
        end else begin
            s1_r    <= flag_raw;
            s2_r    <= s1_r;
            cnt_r   <= cnt_nxt;
            qual_r  <= qual_nxt;
            event_r <= event_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_QUAL_AFTER_BLANK: assert property ($rose(qual_r) |->
        $past(cnt_r) == W'(BLANK_CYC - 1) && $past(s2_r))
        else $error("flag qualified before the blanking time ran out");

    AST_QUAL_DROPS: assert property (!s2_r |=> !qual_r && cnt_r == '0)
        else $error("short flag pulse was not rejected");

endmodule : cpp_qualify

//--- design/cpp_protect.sv
module cpp_protect #(
    parameter int unsigned POR_DELAY_CYC = cpp_pkg::POR_DELAY_CYC,
    parameter int unsigned BLANK_CYC     = cpp_pkg::BLANK_CYC,
    parameter int unsigned SS_STEP_CYC   = cpp_pkg::SS_STEP_CYC
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Supply and comparator flags.
    input  wire logic        vin_above_por,
    input  wire logic        input_surge_comparator,
    input  wire logic        excess_current_comparator,
    input  wire logic        battery_high_comparator,
    input  wire logic        temp_hot,
    input  wire logic        temp_cool,
    // Host enable, active low.
    input  wire logic        enable_n,
    // Pass switch control.
    output logic             pass_switch_on,
    output logic [7:0]       ramp_level,
    // Open-drain fault line toward the host.
    output logic             fault_o,
    output logic             fault_oe_n
);
    localparam int unsigned PW = $clog2(POR_DELAY_CYC + 1);
    localparam int unsigned DW = $clog2(SS_STEP_CYC + 1);
    localparam int unsigned CW = cpp_pkg::CNT_W;
    localparam int unsigned RW = cpp_pkg::RAMP_W;

    logic [cpp_pkg::SYN_N-1:0] syn_raw;
    logic [cpp_pkg::SYN_N-1:0] syn1_r;
    logic [cpp_pkg::SYN_N-1:0] syn2_r;
    logic                      por_ok;
    logic                      surge;
    logic                      en_off;
    logic                      bov_q;
    logic                      bov_ev;
    logic                      oc_q;
    logic                      oc_ev;
    logic                      block;

    cpp_pkg::cpp_state_t state_r;
    cpp_pkg::cpp_state_t state_nxt;
    logic [PW-1:0]       por_cnt_r;
    logic [PW-1:0]       por_cnt_nxt;
    logic [DW-1:0]       ss_div_r;
    logic [DW-1:0]       ss_div_nxt;
    logic [RW-1:0]       ramp_r;
    logic [RW-1:0]       ramp_nxt;
    logic                sw_r;
    logic                sw_nxt;
    logic [CW-1:0]       bov_cnt_r;
    logic [CW-1:0]       bov_cnt_nxt;
    logic                bov_lat_r;
    logic                bov_lat_nxt;
    logic [CW-1:0]       oc_cnt_r;
    logic [CW-1:0]       oc_cnt_nxt;
    logic                oc_lat_r;
    logic                oc_lat_nxt;
    logic                hot_r;
    logic                hot_nxt;
    logic                fault_oe_n_r;
    logic                fault_oe_n_nxt;
    logic                fault_o_r;

    assign syn_raw = {enable_n, temp_cool, temp_hot, input_surge_comparator, vin_above_por};

    // Pin inputs cross into the clock domain through two flip-flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            syn1_r <= cpp_pkg::SYN_RESET;
            syn2_r <= cpp_pkg::SYN_RESET;
        end else begin
            syn1_r <= syn_raw;
            syn2_r <= syn1_r;
        end
    end

    assign por_ok = syn2_r[cpp_pkg::SYN_VIN];
    assign surge  = syn2_r[cpp_pkg::SYN_SURGE];
    assign en_off = syn2_r[cpp_pkg::SYN_EN_N];

    cpp_qualify #(
        .BLANK_CYC (BLANK_CYC)
    ) u_bov_qual (
        .clk      (clk),
        .rst      (rst),
        .flag_raw (battery_high_comparator),
        .qual_r   (bov_q),
        .event_r  (bov_ev)
    );

    cpp_qualify #(
        .BLANK_CYC (BLANK_CYC)
    ) u_oc_qual (
        .clk      (clk),
        .rst      (rst),
        .flag_raw (excess_current_comparator),
        .qual_r   (oc_q),
        .event_r  (oc_ev)
    );

    // Anything but low supply that must keep the pass switch off right now.
    assign block = surge | hot_r | en_off | bov_q | oc_q | bov_lat_r | oc_lat_r;

    always_comb begin
        state_nxt      = state_r;
        por_cnt_nxt    = por_cnt_r;
        ss_div_nxt     = ss_div_r;
        ramp_nxt       = ramp_r;
        bov_cnt_nxt    = bov_cnt_r;
        bov_lat_nxt    = bov_lat_r;
        oc_cnt_nxt     = oc_cnt_r;
        oc_lat_nxt     = oc_lat_r;
        hot_nxt        = hot_r;
        if (syn2_r[cpp_pkg::SYN_HOT]) begin
            hot_nxt = 1'b1;
        end else if (syn2_r[cpp_pkg::SYN_COOL]) begin
            hot_nxt = 1'b0;
        end
        if (bov_ev) begin
            if (bov_cnt_r == cpp_pkg::CNT_LAST) begin
                bov_lat_nxt = 1'b1;
            end else begin
                bov_cnt_nxt = bov_cnt_r + 1'b1;
            end
        end
        if (en_off) begin
            oc_cnt_nxt = '0;
            oc_lat_nxt = 1'b0;
        end else if (oc_ev) begin
            if (oc_cnt_r == cpp_pkg::CNT_LAST) begin
                oc_lat_nxt = 1'b1;
            end else begin
                oc_cnt_nxt = oc_cnt_r + 1'b1;
            end
        end
        case (state_r)
            cpp_pkg::ST_POR: begin
                ramp_nxt    = '0;
                bov_cnt_nxt = '0;
                bov_lat_nxt = 1'b0;
                oc_cnt_nxt  = '0;
                oc_lat_nxt  = 1'b0;
                if (!por_ok) begin
                    por_cnt_nxt = '0;
                end else if (por_cnt_r == PW'(POR_DELAY_CYC - 1)) begin
                    por_cnt_nxt = '0;
                    state_nxt   = cpp_pkg::ST_HOLD;
                end else begin
                    por_cnt_nxt = por_cnt_r + 1'b1;
                end
            end
            cpp_pkg::ST_HOLD: begin
                ramp_nxt   = '0;
                ss_div_nxt = '0;
                if (!block) begin
                    state_nxt = cpp_pkg::ST_SOFT;
                end
            end
            cpp_pkg::ST_SOFT: begin
                if (ss_div_r == DW'(SS_STEP_CYC - 1)) begin
                    ss_div_nxt = '0;
                    ramp_nxt   = ramp_r + 1'b1;
                    if (ramp_r == cpp_pkg::RAMP_FULL - 8'h01) begin
                        state_nxt = cpp_pkg::ST_ON;
                    end
                end else begin
                    ss_div_nxt = ss_div_r + 1'b1;
                end
            end
            cpp_pkg::ST_ON: begin
                ramp_nxt = cpp_pkg::RAMP_FULL;
            end
            default: begin
                state_nxt = cpp_pkg::ST_POR;
            end
        endcase
        if (state_r != cpp_pkg::ST_POR && block) begin
            state_nxt = cpp_pkg::ST_HOLD;
            ramp_nxt  = '0;
        end
        if (!por_ok) begin
            state_nxt = cpp_pkg::ST_POR;
            ramp_nxt  = '0;
        end
        sw_nxt = (state_nxt == cpp_pkg::ST_SOFT) || (state_nxt == cpp_pkg::ST_ON);
        fault_oe_n_nxt = !(por_ok && (surge | hot_r | bov_q | oc_q | bov_lat_r | oc_lat_r));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r      <= cpp_pkg::ST_POR;
            por_cnt_r    <= '0;
            ss_div_r     <= '0;
            ramp_r       <= '0;
            sw_r         <= 1'b0;
            bov_cnt_r    <= '0;
            bov_lat_r    <= 1'b0;
            oc_cnt_r     <= '0;
            oc_lat_r     <= 1'b0;
            hot_r        <= 1'b0;
            fault_oe_n_r <= 1'b1;
            fault_o_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            por_cnt_r    <= por_cnt_nxt;
            ss_div_r     <= ss_div_nxt;
            ramp_r       <= ramp_nxt;
            sw_r         <= sw_nxt;
            bov_cnt_r    <= bov_cnt_nxt;
            bov_lat_r    <= bov_lat_nxt;
            oc_cnt_r     <= oc_cnt_nxt;
            oc_lat_r     <= oc_lat_nxt;
            hot_r        <= hot_nxt;
            fault_oe_n_r <= fault_oe_n_nxt;
            fault_o_r    <= 1'b0;
        end
    end

    assign pass_switch_on = sw_r;
    assign ramp_level     = ramp_r;
    assign fault_o        = fault_o_r;
    assign fault_oe_n     = fault_oe_n_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_turn_on;
        !sw_r ##1 sw_r;
    endsequence

    sequence seq_settled;
        state_r == cpp_pkg::ST_POR ##1 state_r == cpp_pkg::ST_HOLD;
    endsequence

    AST_POR_OFF: assert property (!por_ok |=> !sw_r && state_r == cpp_pkg::ST_POR)
        else $error("switch on below the power-on level");

    AST_SETTLE_TIME: assert property (seq_settled |->
        $past(por_cnt_r) == PW'(POR_DELAY_CYC - 1) && $past(por_ok))
        else $error("settling ended at the wrong count");

    AST_RAMP_START: assert property (seq_turn_on |-> ramp_r == '0)
        else $error("switch turned on without starting the ramp at zero");

    AST_RAMP_STEP: assert property (sw_r && $changed(ramp_r) |->
        ramp_r == $past(ramp_r) + 1'b1)
        else $error("ramp jumped by more than one step");

    AST_SURGE_OFF: assert property (surge |=> !sw_r)
        else $error("surge did not turn the switch off");

    AST_SURGE_RESTART: assert property (seq_turn_on |->
        state_r == cpp_pkg::ST_SOFT && $past(state_r) == cpp_pkg::ST_HOLD)
        else $error("switch came back without soft-start");

    AST_SURGE_AT_SETTLE: assert property (seq_settled ##0 surge |=> !sw_r)
        else $error("output enabled with surge present at settling end");

    AST_BOV_OFF: assert property ($rose(bov_q) |=> !sw_r)
        else $error("qualified battery fault left the switch on");

    AST_BOV_LATCH: assert property (bov_ev && bov_cnt_r == cpp_pkg::CNT_LAST && por_ok
        |=> bov_lat_r ##1 !sw_r)
        else $error("sixteenth battery event did not latch off");

    AST_BOV_HOLD: assert property (bov_lat_r && por_ok |=> bov_lat_r)
        else $error("battery latch released without a power cycle");

    AST_OC_LATCH: assert property (oc_ev && oc_cnt_r == cpp_pkg::CNT_LAST && por_ok
        && !en_off |=> oc_lat_r)
        else $error("sixteenth current event did not latch off");

    AST_THERM: assert property (hot_r && !syn2_r[cpp_pkg::SYN_COOL] |=> hot_r && !sw_r)
        else $error("thermal shutdown released above the low threshold");

    AST_FAULT_LOW: assert property (por_ok && (surge || bov_q || oc_q) |=> !fault_oe_n)
        else $error("fault line not driven during a protection event");

    AST_ENABLE: assert property (en_off |=> !sw_r && !oc_lat_r && oc_cnt_r == '0)
        else $error("disable did not hold off or clear the current latch");

endmodule : cpp_protect

//--- testbench/cpp_host_model.sv
module cpp_host_model (
    // Clock.
    input  wire logic clk,
    // Open-drain fault pin from the block.
    input  wire logic fault_o,
    input  wire logic fault_oe_n,
    // Host request to disable the block.
    input  wire logic en_req,
    // Resolved pin and host enable.
    output logic      fault_pin,
    output logic      enable_n,
    output int        fault_falls
);
    timeunit 1ns;
    timeprecision 1ns;

    logic last_pin = 1'b1;
    int   falls_r  = 0;

    // The pull-up holds the pin high unless the block sinks it.
    assign fault_pin = fault_oe_n ? 1'b1 : fault_o;
    // Low enables the block; the host drives the level directly.
    assign enable_n = en_req;

    assign fault_falls = falls_r;

    // Each falling edge is one fault notice to the host.
    always @(posedge clk) begin
        if (last_pin === 1'b1 && fault_pin === 1'b0) begin
            falls_r <= falls_r + 1;
        end
        last_pin <= fault_pin;
    end
endmodule : cpp_host_model

//--- testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned POR_CYC = 20;
    localparam int unsigned BLK     = 8;
    localparam int unsigned SS      = 2;
    localparam int          TMO     = 40000;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       vin = 1'b0;
    logic       hot = 1'b0;
    logic       cool = 1'b1;
    logic       en_req = 1'b0;
    logic [2:0] flg = 3'h0;
    logic       pass_switch_on;
    logic [7:0] ramp_level;
    logic       fault_o;
    logic       fault_oe_n;
    logic       fault_pin;
    logic       enable_n;
    int         fault_falls;
    int         n_mismatch = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         cnt = 0;
    int         ff = 0;

    always #50 clk = ~clk;

    cpp_protect #(.POR_DELAY_CYC(POR_CYC), .BLANK_CYC(BLK), .SS_STEP_CYC(SS)) i_dut (
        .clk(clk), .rst(rst), .vin_above_por(vin),
        .input_surge_comparator(flg[0]), .excess_current_comparator(flg[2]),
        .battery_high_comparator(flg[1]), .temp_hot(hot), .temp_cool(cool),
        .enable_n(enable_n), .pass_switch_on(pass_switch_on), .ramp_level(ramp_level),
        .fault_o(fault_o), .fault_oe_n(fault_oe_n)
    );

    cpp_host_model i_host (
        .clk(clk), .fault_o(fault_o), .fault_oe_n(fault_oe_n), .en_req(en_req),
        .fault_pin(fault_pin), .enable_n(enable_n), .fault_falls(fault_falls)
    );

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == TMO) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: run exceeded its cycle budget", $time);
            summarize();
        end
    end

    task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] probe(int sel);
        case (sel)
            0: return {7'h00, pass_switch_on};
            1: return {7'h00, fault_pin};
            default: return ramp_level;
        endcase
    endfunction : probe

    // Waits at most max cycles for the probed output to reach exp.
    task automatic wait_for(int sel, logic [7:0] exp, int max);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < max && !ok; i++) begin
            @(negedge clk);
            ok = (probe(sel) === exp);
        end
        chk({7'h00, ok}, 8'h01, "output reached expected value in time");
    endtask : wait_for

    // Checks that the probed output keeps exp for n cycles.
    task automatic stay(int sel, logic [7:0] exp, int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            ok = ok & (probe(sel) === exp);
        end
        chk({7'h00, ok}, 8'h01, "output held its value");
    endtask : stay

    task automatic set(int s, logic v);
        @(posedge clk);
        flg[s] <= v;
    endtask : set

    task automatic test_end(string name);
        $display("Test %s finished, mismatches so far %0d", name, n_mismatch);
    endtask : test_end

    // Power cycle; with surge set the supply comes up during an input surge.
    task automatic powerup(logic surge);
        @(posedge clk);
        vin <= 1'b0;
        repeat (4) @(posedge clk);
        vin <= 1'b1;
        flg[0] <= surge;
        cnt = 0;
        stay(0, 8'h00, POR_CYC);
        if (surge) begin
            stay(0, 8'h00, 40);
            set(0, 1'b0);
        end
        wait_for(0, 8'h01, 20);
        chk(ramp_level, 8'h00, "ramp starts from zero");
        stay(0, 8'h01, 4);
        chk({7'h00, ramp_level < 8'h05}, 8'h01, "ramp rises gradually");
        wait_for(2, 8'hFF, 255 * SS + 20);
    endtask : powerup

    // One qualified event on guard s; the model counter predicts the latch.
    task automatic qual_event(int s);
        set(s, 1'b1);
        stay(0, 8'h01, BLK);
        wait_for(0, 8'h00, 10);
        set(s, 1'b0);
        cnt = cnt + 1;
        if (cnt < 16) begin
            wait_for(0, 8'h01, 12);
        end else begin
            stay(0, 8'h00, 40);
        end
    endtask : qual_event

    // A latch still set keeps the fault line low; enable alone never pulls it.
    task automatic toggle_enable(logic [7:0] fault_exp);
        @(posedge clk);
        en_req <= 1'b1;
        stay(0, 8'h00, 6);
        chk({7'h00, fault_pin}, fault_exp, "fault line while disabled");
        @(posedge clk);
        en_req <= 1'b0;
    endtask : toggle_enable

    initial begin
        void'($urandom(54));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        stay(0, 8'h00, 30);
        powerup(1'b0);
        test_end("power_up");
        ff = fault_falls;
        set(0, 1'b1);
        stay(0, 8'h01, 2);
        wait_for(0, 8'h00, 8);
        chk({7'h00, fault_pin}, 8'h00, "fault pin low during surge");
        @(negedge clk);
        chk(8'(fault_falls - ff), 8'h01, "one fault notice");
        set(0, 1'b0);
        wait_for(0, 8'h01, 10);
        chk(ramp_level, 8'h00, "soft-start reruns from zero");
        wait_for(1, 8'h01, 5);
        test_end("input_surge");
        powerup(1'b1);
        test_end("surge_at_power_up");
        for (int s = 1; s < 3; s++) begin
            for (int k = 0; k < 6; k++) begin
                int len;
                len = 1 + int'($urandom % (BLK - 2));
                set(s, 1'b1);
                repeat (len - 1) @(posedge clk);
                set(s, 1'b0);
                stay(0, 8'h01, BLK + 4);
            end
        end
        test_end("short_pulses");
        for (int i = 0; i < 16; i++) qual_event(1);
        toggle_enable(8'h00);
        stay(0, 8'h00, 40);
        powerup(1'b0);
        test_end("battery_latch");
        cnt = 0;
        for (int i = 0; i < 16; i++) qual_event(2);
        toggle_enable(8'h01);
        wait_for(0, 8'h01, 10);
        test_end("current_latch");
        @(posedge clk);
        hot <= 1'b1;
        cool <= 1'b0;
        wait_for(0, 8'h00, 8);
        @(posedge clk);
        hot <= 1'b0;
        stay(0, 8'h00, 30);
        @(posedge clk);
        cool <= 1'b1;
        wait_for(0, 8'h01, 10);
        test_end("thermal");
        summarize();
    end
endmodule : testbench
